// ---- bench/host_model.sv ----
// Host processor model: byte bus cycles and acknowledge pulses.
// Assumes the caller waits for each task to return before the next.
`timescale 1ns/1ps
`default_nettype none

module host_model (
   // Toward the device
   output logic            cs_n,
   output logic            cmd_data_select,
   output logic            rd_n,
   output logic            wr_n,
   output logic      [7:0] data_in,
   output logic            done_ack_n,
   output logic            service_ack_n,
   // Clock, and from the device
   input  wire logic       mclk,
   input  wire logic       ready,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe_n
);
   initial begin
      cs_n = 1'b1;
      cmd_data_select = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data_in = 8'h00;
      done_ack_n = 1'b1;
      service_ack_n = 1'b1;
   end

   // ==========================================================
   // One byte per cycle; everything held until ready returns
   task automatic access(input logic a0, input logic rd, input logic [7:0] w,
                         output logic [7:0] r, output logic ok);
      int n;
      @(posedge mclk);
      cs_n <= 1'b0;
      cmd_data_select <= a0;
      data_in <= w;
      rd_n <= ~rd;
      wr_n <= rd;
      for (n = 0; n < 8 && ready !== 1'b0; n++) @(posedge mclk);
      for (n = 0; n < 3000 && ready !== 1'b1; n++) @(posedge mclk);
      r = data_out;
      ok = (ready === 1'b1) && (!rd || data_oe_n === 1'b0);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      // Released pins must not keep showing the old byte
      data_in <= ~w;
      repeat (6) @(posedge mclk);
   endtask

   task automatic pulse(input logic svc);
      @(posedge mclk);
      if (svc) service_ack_n <= 1'b0;
      else done_ack_n <= 1'b0;
      repeat (8) @(posedge mclk);
      service_ack_n <= 1'b1;
      done_ack_n <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask
endmodule

`default_nettype wire

// ---- bench/sap_monitor.sv ----
// Checker for the stack arithmetic processor port, bound to its pins.
// Assumes one clock, mclk, and the asynchronous active-low rst_b.
`timescale 1ns/1ps
`default_nettype none

module sap_monitor #(
   parameter int LN_CYCLES  = 4298,
   parameter int LOG_CYCLES = 4474
) (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       ce,
   // Host bus
   input wire logic       cs_n,
   input wire logic       cmd_data_select,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic       data_oe_n,
   input wire logic       ready,
   // Completion handshakes
   input wire logic       end_n,
   input wire logic       done_ack_n,
   input wire logic       service_request,
   input wire logic       service_ack_n
);
   // ==========================================================
   // Pin relations; the pin filter costs about four cycles
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_reset_quiet: assert property ($rose(rst_b) |-> ready && end_n && !service_request && data_oe_n)
      else $error("outputs not idle after reset");
   a_idle_ready: assert property ((cs_n && rd_n && wr_n) [*6] |-> ready)
      else $error("ready low with no access");
   a_write_stalls: assert property ($fell(wr_n) && !cs_n |-> ##[1:6] !ready)
      else $error("ready not pulled low by a write");
   a_read_stalls: assert property ($fell(rd_n) && !cs_n |-> ##[1:6] !ready)
      else $error("ready not pulled low by a read");
   a_status_fast: assert property ($fell(rd_n) && !cs_n && cmd_data_select |-> ##[2:9] !data_oe_n)
      else $error("status read not answered promptly");
   a_drive_ready: assert property (!data_oe_n |-> ready)
      else $error("bus driven while ready low");
   a_request_end: assert property ($rose(service_request) |-> $fell(end_n))
      else $error("service request not raised with end");
   a_end_ack: assert property ((!done_ack_n) [*6] |-> end_n)
      else $error("end line not released by acknowledge");
   a_service_ack: assert property ((!service_ack_n) [*6] |-> !service_request)
      else $error("service request not dropped by acknowledge");
endmodule

bind stack_arith_processor_port sap_monitor #(.LN_CYCLES(LN_CYCLES), .LOG_CYCLES(LOG_CYCLES)) mon (
   .mclk, .rst_b, .ce, .cs_n, .cmd_data_select, .rd_n, .wr_n, .data_in, .data_out,
   .data_oe_n, .ready, .end_n, .done_ack_n, .service_request, .service_ack_n);

`default_nettype wire

// ---- bench/tb_stack_arith_processor_port.sv ----
// Self-checking bench of the stack arithmetic processor port.
// Assumes host_model drives the bus and sap_monitor is bound to the port.
`timescale 1ns/1ps
`default_nettype none

module tb_stack_arith_processor_port;
   import sap_pkg::*;
   logic       mclk = 1'b0;
   logic       rst_b = 1'b0;
   logic       ce = 1'b1;
   logic       cs_n, cmd_data_select, rd_n, wr_n, done_ack_n, service_ack_n;
   logic       data_oe_n, ready, end_n, service_request;
   logic [7:0] data_in, data_out, d;
   int         bad_count = 0;
   int         checked = 0;

   always #5 mclk = ~mclk;

   // Short ln so that the busy scenarios stay brief
   stack_arith_processor_port #(.LN_CYCLES(400), .LOG_CYCLES(24)) uut (
      .mclk(mclk), .rst_b(rst_b), .ce(ce), .cs_n(cs_n), .cmd_data_select(cmd_data_select),
      .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .ready(ready), .end_n(end_n), .done_ack_n(done_ack_n), .service_request(service_request),
      .service_ack_n(service_ack_n));

   host_model host (
      .cs_n(cs_n), .cmd_data_select(cmd_data_select), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
      .done_ack_n(done_ack_n), .service_ack_n(service_ack_n), .mclk(mclk), .ready(ready),
      .data_out(data_out), .data_oe_n(data_oe_n));

   // ==========================================================
   // Shared tasks
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic xfer(input logic a0, input logic rd, input logic [7:0] w);
      logic ok;
      host.access(a0, rd, w, d, ok);
      if (ok !== 1'b1) begin
         check("bus handshake", 8'h00, 8'h01);
         print_verdict();
      end
   endtask

   task automatic wait_end(output int cnt);
      for (cnt = 0; cnt < 3000 && end_n !== 1'b0; cnt++) @(posedge mclk);
      if (cnt == 3000) begin
         check("end wait", 8'h00, 8'h01);
         print_verdict();
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      check("ready", ready, 8'h01);
      check("end_n", end_n, 8'h01);
      check("service_request", service_request, 8'h00);
      xfer(1'b1, 1'b1, 8'h00);
      check("status after reset", d, 8'h00);
   endtask

   task automatic t_stack();
      for (int i = 0; i < 17; i++) xfer(1'b0, 1'b0, 8'(i));
      for (int i = 16; i > 0; i--) begin
         xfer(1'b0, 1'b1, 8'h00);
         check("pop order", d, 8'(i));
      end
      xfer(1'b0, 1'b1, 8'h00);
      check("rotated byte", d, 8'h10);
   endtask

   task automatic t_add();
      logic [7:0] v [4] = '{8'h03, 8'h00, 8'hFF, 8'hFF};
      int cnt;
      foreach (v[i]) xfer(1'b0, 1'b0, v[i]);
      xfer(1'b1, 1'b0, 8'h6C);
      // Part of the 17 cycles pass inside the command cycle
      wait_end(cnt);
      check("add16 time", 8'(cnt >= 8 && cnt <= 12), 8'h01);
      xfer(1'b1, 1'b1, 8'h00);
      check("add status", d, 8'h01);
      xfer(1'b0, 1'b1, 8'h00);
      check("sum high byte", d, 8'h00);
      xfer(1'b0, 1'b1, 8'h00);
      check("sum low byte", d, 8'h02);
      host.pulse(1'b0);
      check("end released", end_n, 8'h01);
   endtask

   task automatic t_svc();
      int cnt;
      xfer(1'b1, 1'b0, 8'h80);
      wait_end(cnt);
      check("request raised", service_request, 8'h01);
      host.pulse(1'b0);
      xfer(1'b1, 1'b0, 8'h00);
      wait_end(cnt);
      check("request dropped", service_request, 8'h00);
      host.pulse(1'b0);
      xfer(1'b1, 1'b0, 8'h80);
      wait_end(cnt);
      host.pulse(1'b1);
      check("request acked", service_request, 8'h00);
      host.pulse(1'b0);
   endtask

   task automatic t_busy();
      time t0;
      xfer(1'b1, 1'b0, 8'h09);
      xfer(1'b1, 1'b1, 8'h00);
      check("busy bit", d[7], 8'h01);
      for (int i = 0; i < 16; i++) xfer(1'b0, 1'b0, 8'(8'h40 + i));
      xfer(1'b0, 1'b0, 8'hAA);
      check("write stalls until done", end_n, 8'h00);
      host.pulse(1'b0);
      xfer(1'b1, 1'b0, 8'h09);
      t0 = $time;
      xfer(1'b1, 1'b0, 8'h00);
      check("command waits", end_n, 8'h00);
      check("command wait time", 8'(($time - t0) > 3000), 8'h01);
      host.pulse(1'b0);
      xfer(1'b1, 1'b0, 8'h09);
      xfer(1'b0, 1'b1, 8'h00);
      check("read waits", end_n, 8'h00);
      check("top after ln", d, 8'hAA);
      host.pulse(1'b0);
   endtask

   task automatic run_cmd(input logic [7:0] c);
      int cnt;
      xfer(1'b1, 1'b0, c);
      wait_end(cnt);
      host.pulse(1'b0);
   endtask

   // Exchange, change sign and subtract chained on 16-bit values, then log
   task automatic t_ops();
      logic [7:0] v [8] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h80, 8'h01};
      logic [7:0] r [4] = '{8'h7F, 8'hDE, 8'h5B, 8'hD8};
      for (int i = 0; i < 4; i++) xfer(1'b0, 1'b0, v[i]);
      run_cmd(8'h79);
      run_cmd(8'h74);
      run_cmd(8'h6D);
      xfer(1'b1, 1'b1, 8'h00);
      check("sub status", d, 8'h01);
      xfer(1'b0, 1'b1, 8'h00);
      check("sub high byte", d, 8'h00);
      xfer(1'b0, 1'b1, 8'h00);
      check("sub low byte", d, 8'h03);
      for (int i = 4; i < 8; i++) xfer(1'b0, 1'b0, v[i]);
      run_cmd(8'h08);
      foreach (r[i]) begin
         xfer(1'b0, 1'b1, 8'h00);
         check("log byte", d, r[i]);
      end
   endtask

   task automatic t_ce();
      int cnt;
      xfer(1'b1, 1'b0, 8'h09);
      ce <= 1'b0;
      repeat (500) @(posedge mclk);
      check("frozen end_n", end_n, 8'h01);
      ce <= 1'b1;
      wait_end(cnt);
      check("frozen ln time", 8'(cnt > 370 && cnt < 400), 8'h01);
      host.pulse(1'b0);
   endtask

   task automatic t_rst_mid();
      xfer(1'b1, 1'b0, 8'h80);
      check("request set", service_request, 8'h01);
      rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      check("end_n after reset", end_n, 8'h01);
      check("request after reset", service_request, 8'h00);
      xfer(1'b0, 1'b1, 8'h00);
      check("stack after reset", d, 8'h00);
   endtask

   initial begin
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_stack();
      t_add();
      t_ops();
      t_svc();
      t_busy();
      t_ce();
      t_rst_mid();
      print_verdict();
   end
endmodule

`default_nettype wire

// ---- rtl/data_fifo.sv ----
// Synchronous FIFO holding stack bytes written by the host.
// Assumes one clock; ce low freezes all state.
`timescale 1ns/1ps
`default_nettype none

module data_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wr_ptr;
      logic [AW:0]                 rd_ptr;
   } fifo_s;

   fifo_s st_reg;
   fifo_s st_next;
   logic  full;
   logic  empty;

   // ==========================================================
   // Flags
   assign empty     = (st_reg.wr_ptr == st_reg.rd_ptr);
   assign full      = (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]) && !empty;
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = st_reg.mem[st_reg.rd_ptr[AW-1:0]];

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      if (in_valid && !full) begin
         st_next.mem[st_reg.wr_ptr[AW-1:0]] = in_data;
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/sap_cfg.svh ----
// Constants of the stack arithmetic processor port: field positions,
// opcodes, execution cycle counts and reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SAP_CFG_SVH
`define SAP_CFG_SVH

// ==========================================================
// Command byte fields
`define CMD_OP_MSB      4
`define CMD_FIX_BIT     5
`define CMD_SGL_BIT     6
`define CMD_SVC_BIT     7

// ==========================================================
// Operation codes (bits 4..0)
`define OP_NOP          5'h00
`define OP_LOG          5'h08
`define OP_LN           5'h09
`define OP_ADD          5'h0C
`define OP_SUB          5'h0D
`define OP_CHS          5'h14
`define OP_XCH          5'h19

// ==========================================================
// Status byte layout
`define ST_BUSY_BIT     7
`define ST_SIGN_BIT     6
`define ST_ZERO_BIT     5
`define ST_ERR_MSB      4
`define ST_ERR_LSB      1
`define ST_CARRY_BIT    0
`define ERR_NONE        4'h0
`define ERR_OVF         4'h1

// ==========================================================
// Execution times in mclk cycles
`define CYC_ADD16       14'd17
`define CYC_SUB16       14'd30
`define CYC_ADD32       14'd21
`define CYC_SUB32       14'd38
`define CYC_CHS16       14'd23
`define CYC_CHS32       14'd27
`define CYC_XCH16       14'd18
`define CYC_XCH32       14'd26
`define CYC_NOP         14'd4
`define CYC_OTHER       14'd16
`define CYC_LN          4298
`define CYC_LOG         4474

// ==========================================================
// Misc
`define LOG10E_Q24      24'h6F2DEC
`define FIFO_DEPTH      16
`define SYNC_W          14
`define SYNC_RST        14'h003F
`define STACK_BYTES     16

`endif

// ---- rtl/sap_pkg.sv ----
// Types shared by the stack arithmetic processor port.
// Assumes sap_cfg.svh is on the include path.
`include "sap_cfg.svh"

package sap_pkg;

   // ==========================================================
   // Bus access state, one-hot
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_WAIT = 3'b010,
      S_DONE = 3'b100
   } bus_state_e;

   // ==========================================================
   // Kind of host access
   typedef enum logic [1:0] {
      ACC_STACK_WR = 2'b00,
      ACC_STACK_RD = 2'b01,
      ACC_CMD_WR   = 2'b10,
      ACC_STAT_RD  = 2'b11
   } access_e;

   typedef logic [`STACK_BYTES-1:0][7:0] stack_t;

endpackage

// ---- rtl/stack_arith_processor_port.sv ----
// Host port and control of a stack arithmetic coprocessor: byte stack,
// command execution timing, status, READY and completion handshakes.
// Assumes an asynchronous host on pins; all host pins are resynchronised.
`timescale 1ns/1ps
`default_nettype none
`include "sap_cfg.svh"

module stack_arith_processor_port #(
   parameter int LN_CYCLES  = `CYC_LN,
   parameter int LOG_CYCLES = `CYC_LOG
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   // Host bus
   input  wire logic       cs_n,
   input  wire logic       cmd_data_select,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe_n,
   output logic            ready,
   // Completion handshakes
   output logic            end_n,
   input  wire logic       done_ack_n,
   output logic            service_request,
   input  wire logic       service_ack_n
);
   import sap_pkg::*;

   typedef struct packed {
      logic [`SYNC_W-1:0] sy1;
      logic [`SYNC_W-1:0] sy2;
      logic [`SYNC_W-1:0] sy3;
      logic [`SYNC_W-1:0] pin;
      bus_state_e         fsm;
      access_e            acc;
      stack_t             stk;
      logic [7:0]         cmd;
      logic               busy;
      logic [13:0]        cnt;
      logic               sign;
      logic               zero;
      logic [3:0]         err;
      logic               carry;
      logic [7:0]         out_latch;
      logic               end_n;
      logic               svc;
   } port_s;

   port_s st_reg;
   port_s st_next;

   // ==========================================================
   // Decoded pins and helpers
   logic        p_cs_n;
   logic        p_a0;
   logic        p_rd_n;
   logic        p_wr_n;
   logic        p_done_ack_n_n;
   logic        p_sack_n;
   logic [7:0]  p_data;
   logic        acc_req;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [7:0]  fifo_out_data;
   logic [4:0]  op;
   logic        fixed;
   logic        dbl;
   logic [15:0] top16;
   logic [15:0] nos16;
   logic [31:0] top32;
   logic [31:0] nos32;
   logic [16:0] add16;
   logic [16:0] sub16;
   logic [32:0] add32;
   logic [32:0] sub32;
   logic [15:0] neg16;
   logic [31:0] neg32;
   logic [47:0] log_prod;
   logic [31:0] log_res;
   logic [31:0] ln_res;
   logic [6:0]  log_exp;

   assign p_cs_n   = st_reg.pin[0];
   assign p_a0     = st_reg.pin[1];
   assign p_rd_n   = st_reg.pin[2];
   assign p_wr_n   = st_reg.pin[3];
   assign p_done_ack_n_n = st_reg.pin[4];
   assign p_sack_n = st_reg.pin[5];
   assign p_data   = st_reg.pin[13:6];
   assign acc_req  = !p_cs_n && (!p_rd_n || !p_wr_n);

   // Top byte sits at index 0; the byte pushed last is the most significant
   assign top16 = {st_reg.stk[0], st_reg.stk[1]};
   assign nos16 = {st_reg.stk[2], st_reg.stk[3]};
   assign top32 = {st_reg.stk[0], st_reg.stk[1], st_reg.stk[2], st_reg.stk[3]};
   assign nos32 = {st_reg.stk[4], st_reg.stk[5], st_reg.stk[6], st_reg.stk[7]};

   assign op    = st_reg.cmd[`CMD_OP_MSB:0];
   assign fixed = st_reg.cmd[`CMD_FIX_BIT];
   assign dbl   = !(fixed && st_reg.cmd[`CMD_SGL_BIT]);

   assign add16 = {1'b0, top16} + {1'b0, nos16};
   assign sub16 = {1'b0, nos16} - {1'b0, top16};
   assign add32 = {1'b0, top32} + {1'b0, nos32};
   assign sub32 = {1'b0, nos32} - {1'b0, top32};
   assign neg16 = 16'h0000 - top16;
   assign neg32 = 32'h0000_0000 - top32;

   // Natural log core is not modelled: it passes the operand through.
   assign ln_res   = top32;
   // Product of two fractions lies in [0.21,0.44): one or two shifts renormalise
   assign log_prod = ln_res[23:0] * `LOG10E_Q24;
   assign log_exp  = ln_res[30:24] - 7'h01;
   always_comb begin
      if (ln_res == 32'h0000_0000) begin
         log_res = 32'h0000_0000;
      end else if (log_prod[46]) begin
         log_res = {ln_res[31], log_exp, log_prod[46:23]};
      end else begin
         log_res = {ln_res[31], 7'(log_exp - 7'h01), log_prod[45:22]};
      end
   end

   // ==========================================================
   // Input latch between bus and stack
   // Draining and filling both stop while a command runs, so the latch never holds more than one byte
   assign fifo_in_valid  = (st_reg.fsm == S_WAIT) && (st_reg.acc == ACC_STACK_WR) && !st_reg.busy;
   assign fifo_out_ready = !st_reg.busy;

   data_fifo #(
      .WIDTH (8),
      .DEPTH (`FIFO_DEPTH)
   ) u_in_fifo (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .ce        (ce),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (p_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ==========================================================
   // Execution time lookup
   function automatic logic [13:0] cycles_of(input logic [7:0] c);
      logic       f;
      logic       s;
      f = c[`CMD_FIX_BIT];
      s = c[`CMD_SGL_BIT];
      cycles_of = `CYC_OTHER;
      unique case (c[`CMD_OP_MSB:0])
         `OP_NOP: cycles_of = `CYC_NOP;
         `OP_ADD: cycles_of = (f && s) ? `CYC_ADD16 : `CYC_ADD32;
         `OP_SUB: cycles_of = (f && s) ? `CYC_SUB16 : `CYC_SUB32;
         `OP_CHS: cycles_of = (f && s) ? `CYC_CHS16 : `CYC_CHS32;
         `OP_XCH: cycles_of = (f && s) ? `CYC_XCH16 : `CYC_XCH32;
         `OP_LN:  cycles_of = LN_CYCLES[13:0];
         `OP_LOG: cycles_of = LOG_CYCLES[13:0];
         default: cycles_of = `CYC_OTHER;
      endcase
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;

      // Three-stage resync; a bit changes once stages two and three agree
      st_next.sy1 = {data_in, service_ack_n, done_ack_n, wr_n, rd_n, cmd_data_select, cs_n};
      st_next.sy2 = st_reg.sy1;
      st_next.sy3 = st_reg.sy2;
      for (int i = 0; i < `SYNC_W; i++) begin
         if (st_reg.sy2[i] == st_reg.sy3[i]) begin
            st_next.pin[i] = st_reg.sy3[i];
         end
      end

      // Drained latch bytes push down the stack; bottom byte falls off
      if (fifo_out_valid && fifo_out_ready) begin
         st_next.stk = {st_reg.stk[14:0], fifo_out_data};
      end

      // Host bus sequencing
      unique case (st_reg.fsm)
         S_IDLE: begin
            if (acc_req) begin
               st_next.acc = access_e'({p_a0, !p_rd_n});
               st_next.fsm = S_WAIT;
            end
         end
         S_WAIT: begin
            unique case (st_reg.acc)
               ACC_STAT_RD: begin
                  st_next.out_latch = {st_reg.busy, st_reg.sign, st_reg.zero, st_reg.err, st_reg.carry};
                  st_next.fsm       = S_DONE;
               end
               ACC_CMD_WR: begin
                  // Operands still in the latch must reach the stack first
                  if (!st_reg.busy && !fifo_out_valid) begin
                     st_next.cmd  = p_data;
                     st_next.busy = 1'b1;
                     st_next.cnt  = cycles_of(p_data);
                     st_next.fsm  = S_DONE;
                  end
               end
               ACC_STACK_WR: begin
                  if (!st_reg.busy && fifo_in_ready) begin
                     st_next.fsm = S_DONE;
                  end
               end
               ACC_STACK_RD: begin
                  if (!st_reg.busy && !fifo_out_valid) begin
                     st_next.out_latch = st_reg.stk[0];
                     st_next.stk       = {st_reg.stk[0], st_reg.stk[15:1]};
                     st_next.fsm       = S_DONE;
                  end
               end
            endcase
         end
         S_DONE: begin
            // Wait for the strobe to go away before taking the next access
            if (!acc_req) begin
               st_next.fsm = S_IDLE;
            end
         end
         default: st_next.fsm = S_IDLE;
      endcase

      // Acknowledges first, so a completion in the same cycle wins
      if (!p_done_ack_n_n) begin
         st_next.end_n = 1'b1;
      end
      if (!p_sack_n) begin
         st_next.svc = 1'b0;
      end

      // Command execution
      if (st_reg.busy) begin
         if (st_reg.cnt > 14'd1) begin
            st_next.cnt = st_reg.cnt - 14'd1;
         end else begin
            st_next.busy  = 1'b0;
            st_next.end_n = 1'b0;
            st_next.svc   = st_reg.cmd[`CMD_SVC_BIT];
            st_next.err   = `ERR_NONE;
            st_next.carry = 1'b0;
            unique case (op)
               `OP_ADD: begin
                  if (!dbl) begin
                     st_next.stk   = {st_reg.stk[1:0], st_reg.stk[15:4], add16[7:0], add16[15:8]};
                     st_next.carry = add16[16];
                     if ((top16[15] == nos16[15]) && (add16[15] != top16[15])) begin
                        st_next.err = `ERR_OVF;
                     end
                  end else begin
                     st_next.stk   = {st_reg.stk[3:0], st_reg.stk[15:8],
                                      add32[7:0], add32[15:8], add32[23:16], add32[31:24]};
                     st_next.carry = add32[32];
                     if ((top32[31] == nos32[31]) && (add32[31] != top32[31])) begin
                        st_next.err = `ERR_OVF;
                     end
                  end
               end
               `OP_SUB: begin
                  if (!dbl) begin
                     st_next.stk   = {st_reg.stk[1:0], st_reg.stk[15:4], sub16[7:0], sub16[15:8]};
                     st_next.carry = sub16[16];
                     if ((top16[15] != nos16[15]) && (sub16[15] != nos16[15])) begin
                        st_next.err = `ERR_OVF;
                     end
                  end else begin
                     st_next.stk   = {st_reg.stk[3:0], st_reg.stk[15:8],
                                      sub32[7:0], sub32[15:8], sub32[23:16], sub32[31:24]};
                     st_next.carry = sub32[32];
                     if ((top32[31] != nos32[31]) && (sub32[31] != nos32[31])) begin
                        st_next.err = `ERR_OVF;
                     end
                  end
               end
               `OP_CHS: begin
                  // Single operand: only the top value changes
                  if (!dbl) begin
                     st_next.stk = {st_reg.stk[15:2], neg16[7:0], neg16[15:8]};
                     if (top16 == 16'h8000) begin
                        st_next.err = `ERR_OVF;
                     end
                  end else begin
                     st_next.stk = {st_reg.stk[15:4], neg32[7:0], neg32[15:8], neg32[23:16], neg32[31:24]};
                     if (top32 == 32'h8000_0000) begin
                        st_next.err = `ERR_OVF;
                     end
                  end
               end
               `OP_XCH: begin
                  if (!dbl) begin
                     st_next.stk = {st_reg.stk[15:4], st_reg.stk[1:0], st_reg.stk[3:2]};
                  end else begin
                     st_next.stk = {st_reg.stk[15:8], st_reg.stk[3:0], st_reg.stk[7:4]};
                  end
               end
               `OP_LOG: begin
                  st_next.stk = {st_reg.stk[15:4], log_res[7:0], log_res[15:8],
                                 log_res[23:16], log_res[31:24]};
               end
               default: begin
                  st_next.stk = st_reg.stk;
               end
            endcase
            // Sign and zero describe the new top value
            st_next.sign = st_next.stk[0][7];
            if (dbl) begin
               st_next.zero = ({st_next.stk[0], st_next.stk[1], st_next.stk[2], st_next.stk[3]} == 32'h0);
            end else begin
               st_next.zero = ({st_next.stk[0], st_next.stk[1]} == 16'h0);
            end
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg       <= '0;
         st_reg.sy1   <= `SYNC_RST;
         st_reg.sy2   <= `SYNC_RST;
         st_reg.sy3   <= `SYNC_RST;
         st_reg.pin   <= `SYNC_RST;
         st_reg.fsm   <= S_IDLE;
         st_reg.acc   <= ACC_STACK_WR;
         st_reg.end_n <= 1'b1;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   // READY drops as soon as an access is seen and rises when it is served
   assign ready           = !((st_reg.fsm == S_WAIT) || ((st_reg.fsm == S_IDLE) && acc_req));
   assign data_out        = st_reg.out_latch;
   assign data_oe_n       = !((st_reg.fsm == S_DONE) && st_reg.acc[0]);
   assign end_n           = st_reg.end_n;
   assign service_request = st_reg.svc;

endmodule

`default_nettype wire
